// >>> core/frps_pkg.sv
// Package: constants and types for the flash row program sequencer host
package frps_pkg;

    // ******************************************************************
    // Clock and timing
    // ******************************************************************
    localparam int unsigned CLK_MHZ = 40;

    // Interval figures in microseconds; none is given here, plain defaults
    localparam int unsigned NONVOLATILE_SETUP_US = 10;
    localparam int unsigned PROGRAM_SETUP_US     = 5;
    localparam int unsigned BYTE_PROGRAM_US      = 30;
    localparam int unsigned NONVOLATILE_HOLD_US  = 5;
    localparam int unsigned RECOVERY_US          = 1;

    // Least times, so round up (whole microseconds give exact counts)
    localparam int unsigned NVS_CYC  = NONVOLATILE_SETUP_US * CLK_MHZ;
    localparam int unsigned PGS_CYC  = PROGRAM_SETUP_US * CLK_MHZ;
    localparam int unsigned PROG_CYC = BYTE_PROGRAM_US * CLK_MHZ;
    localparam int unsigned NVH_CYC  = NONVOLATILE_HOLD_US * CLK_MHZ;
    localparam int unsigned RCV_CYC  = RECOVERY_US * CLK_MHZ;

    localparam int unsigned CNT_W = 12;

    // ******************************************************************
    // Device map
    // ******************************************************************
    localparam logic [15:0] ARRAY_CONTROL_REG_ADDR = 16'hfe08;
    localparam logic [15:0] BLOCK_PROTECT_REG_ADDR = 16'hff7e;
    localparam logic [15:0] ARRAY_LO_ADDR          = 16'h0450;
    localparam logic [15:0] ARRAY_HI_ADDR          = 16'h7fff;
    localparam logic [15:0] ROW_BASE_MASK          = 16'hffc0;
    localparam logic [15:0] PROTECT_BIT15          = 16'h8000;

    localparam int unsigned ROW_BYTES = 64;
    localparam int unsigned ROW_IDX_W = 6;

    // Control register bits
    localparam int unsigned PROGRAM_SELECT_BIT      = 0;
    localparam int unsigned ERASE_SELECT_BIT        = 1;
    localparam int unsigned HIGH_VOLTAGE_ENABLE_BIT = 3;
    localparam logic [7:0]  CTRL_IDLE               = 8'h00;

    // ******************************************************************
    // Types
    // ******************************************************************
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } frps_bus_t;

    typedef struct packed {
        logic [15:0] row_addr;
        logic [5:0]  count_m1;
    } frps_cmd_t;

    typedef enum logic [1:0] {
        FRPS_OK,
        FRPS_ERR_PROTECT,
        FRPS_ERR_RANGE,
        FRPS_ERR_SUSPEND
    } frps_status_t;

endpackage

// >>> core/frps_wait_timer.sv
// Wait timer: counts a loaded number of cycles and flags the end
`timescale 1ns/1ps
module frps_wait_timer
(
    // Clock and reset
    input  wire logic                      i_core_clk,
    input  wire logic                      i_rst,
    // Control
    input  wire logic                      i_load,
    input  wire logic [frps_pkg::CNT_W-1:0] i_cycles,
    // Status
    output logic                           o_done
);

    logic [frps_pkg::CNT_W-1:0] cnt_ff;
    logic [frps_pkg::CNT_W-1:0] nxt_cnt;
    logic                       done_ff;
    logic                       nxt_done;

    always_comb
    begin
        nxt_cnt  = cnt_ff;
        nxt_done = 1'b0;
        if (i_load)
        begin
            nxt_cnt = i_cycles;
        end
        else if (cnt_ff != '0)
        begin
            nxt_cnt  = cnt_ff - 1'b1;
            nxt_done = (cnt_ff == {{(frps_pkg::CNT_W-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            cnt_ff  <= '0;
            done_ff <= 1'b0;
        end
        else
        begin
            cnt_ff  <= nxt_cnt;
            done_ff <= nxt_done;
        end
    end

    assign o_done = done_ff;

endmodule

// >>> core/frps_host.sv
// Host sequencer that programs one flash row through the device's bus
`timescale 1ns/1ps
module frps_host
(
    // Clock and reset
    input  wire logic                   i_core_clk,
    input  wire logic                   i_rst,
    // User command
    input  wire logic                   i_start,
    input  wire frps_pkg::frps_cmd_t    i_cmd,
    input  wire logic [7:0]             i_data,
    output logic                        o_data_req,
    output logic                        o_busy,
    output logic                        o_done,
    output frps_pkg::frps_status_t      o_status,
    // Core low power request, from another domain
    input  wire logic                   i_halt_req,
    // Device bus
    output frps_pkg::frps_bus_t         o_bus,
    input  wire logic [7:0]             i_bus_rdata
);
    typedef enum {
        S_IDLE, S_SET_PGM, S_RD_BPR, S_CHECK, S_SEL_ROW, S_WAIT_NVS, S_SET_HV, S_WAIT_PGS,
        S_REQ, S_WR_BYTE, S_WAIT_PROG, S_CLR_PGM, S_WAIT_NVH, S_CLR_HV, S_WAIT_RCV
    } frps_state_t;
    // ******************************************************************
    // Helpers
    // ******************************************************************
    function automatic logic [7:0] ctrl_val(input logic program_select, input logic hv);
        logic [7:0] v;
        v = frps_pkg::CTRL_IDLE;
        v[frps_pkg::PROGRAM_SELECT_BIT]      = program_select;
        v[frps_pkg::HIGH_VOLTAGE_ENABLE_BIT] = hv;
        return v;
    endfunction

    function automatic logic in_array(input logic [15:0] a);
        return (a >= frps_pkg::ARRAY_LO_ADDR) && (a <= frps_pkg::ARRAY_HI_ADDR);
    endfunction
    // ******************************************************************
    // Halt request synchroniser
    // ******************************************************************
    logic halt_meta_ff;
    logic halt_ff;

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            halt_meta_ff <= 1'b0;
            halt_ff      <= 1'b0;
        end
        else
        begin
            halt_meta_ff <= i_halt_req;
            halt_ff      <= halt_meta_ff;
        end
    end
    // ******************************************************************
    // Sequencer
    // ******************************************************************
    frps_state_t            state_ff,  nxt_state;
    frps_pkg::frps_bus_t    bus_ff,    nxt_bus;
    frps_pkg::frps_status_t status_ff, nxt_status;
    logic [15:0]            row_ff,    nxt_row;
    logic [5:0]             idx_ff,    nxt_idx;
    logic [5:0]             last_ff,   nxt_last;
    logic                   hv_ff,     nxt_hv;
    logic                   req_ff,    nxt_req;
    logic                   busy_ff,   nxt_busy;
    logic                   done_ff,   nxt_done;
    logic                   tmr_load;
    logic [frps_pkg::CNT_W-1:0] tmr_cyc;
    logic                   tmr_done;
    logic [15:0]            prot_start;
    logic [15:0]            row_end;
    frps_wait_timer u_timer
    (
        .i_core_clk (i_core_clk), .i_rst (i_rst), .i_load (tmr_load), .i_cycles (tmr_cyc),
        .o_done     (tmr_done)
    );

    always_comb
    begin
        nxt_state  = state_ff;
        nxt_bus    = bus_ff;
        nxt_status = status_ff;
        nxt_row    = row_ff;
        nxt_idx    = idx_ff;
        nxt_last   = last_ff;
        nxt_hv     = hv_ff;
        nxt_req    = 1'b0;
        nxt_busy   = busy_ff;
        nxt_done   = 1'b0;
        tmr_load   = 1'b0;
        tmr_cyc    = '0;
        nxt_bus.wr = 1'b0;
        nxt_bus.rd = 1'b0;
        prot_start = frps_pkg::PROTECT_BIT15 | {1'b0, i_bus_rdata, 7'h00};
        row_end    = row_ff + 16'(frps_pkg::ROW_BYTES - 1);

        unique case (state_ff)
            S_IDLE:
            begin
                // Row erased beforehand by caller; idle halt leaves array alone
                if (i_start && !halt_ff)
                begin
                    nxt_row    = i_cmd.row_addr & frps_pkg::ROW_BASE_MASK;
                    nxt_last   = i_cmd.count_m1;
                    nxt_idx    = '0;
                    nxt_busy   = 1'b1;
                    nxt_status = frps_pkg::FRPS_OK;
                    nxt_state  = S_SET_PGM;
                end
            end
            S_SET_PGM:
            begin
                // Program select only, never erase
                nxt_bus   = '{frps_pkg::ARRAY_CONTROL_REG_ADDR, ctrl_val(1'b1, 1'b0), 1'b1, 1'b0};
                nxt_state = S_RD_BPR;
            end
            S_RD_BPR:
            begin
                nxt_bus   = '{frps_pkg::BLOCK_PROTECT_REG_ADDR, 8'h00, 1'b0, 1'b1};
                nxt_state = S_CHECK;
            end
            S_CHECK:
            begin
                if (!in_array(row_ff) || !in_array(row_end))
                begin
                    nxt_status = frps_pkg::FRPS_ERR_RANGE;
                    nxt_state  = S_CLR_PGM;
                end
                else
                    nxt_state = S_SEL_ROW;
            end
            S_SEL_ROW:
            begin
                // Protect byte is on the read bus the cycle after the strobe
                if (row_end >= prot_start)
                begin
                    nxt_status = frps_pkg::FRPS_ERR_PROTECT;
                    nxt_state  = S_CLR_PGM;
                end
                else
                begin
                    nxt_bus   = '{row_ff, 8'h00, 1'b1, 1'b0};
                    tmr_load  = 1'b1;
                    tmr_cyc   = frps_pkg::CNT_W'(frps_pkg::NVS_CYC);
                    nxt_state = S_WAIT_NVS;
                end
            end
            S_WAIT_NVS:
                if (tmr_done)
                    nxt_state = S_SET_HV;
            S_SET_HV:
            begin
                // Only reached with program select set and protect cleared
                nxt_bus   = '{frps_pkg::ARRAY_CONTROL_REG_ADDR, ctrl_val(1'b1, 1'b1), 1'b1, 1'b0};
                nxt_hv    = 1'b1;
                tmr_load  = 1'b1;
                tmr_cyc   = frps_pkg::CNT_W'(frps_pkg::PGS_CYC);
                nxt_state = S_WAIT_PGS;
            end
            S_WAIT_PGS:
            begin
                if (tmr_done)
                begin
                    nxt_req   = 1'b1;
                    nxt_state = S_REQ;
                end
            end
            S_REQ:
                // User data must be valid in the cycle after the request
                nxt_state = S_WR_BYTE;
            S_WR_BYTE:
            begin
                // Address stays inside the selected row
                nxt_bus   = '{row_ff | {10'h000, idx_ff}, i_data, 1'b1, 1'b0};
                tmr_load  = 1'b1;
                tmr_cyc   = frps_pkg::CNT_W'(frps_pkg::PROG_CYC);
                nxt_state = S_WAIT_PROG;
            end
            S_WAIT_PROG:
            begin
                // Byte interval waited exactly, keeping spacing bounded
                if (tmr_done)
                begin
                    if (idx_ff == last_ff)
                        nxt_state = S_CLR_PGM;
                    else
                    begin
                        nxt_idx   = idx_ff + 6'h01;
                        nxt_req   = 1'b1;
                        nxt_state = S_REQ;
                    end
                end
            end
            S_CLR_PGM:
            begin
                nxt_bus   = '{frps_pkg::ARRAY_CONTROL_REG_ADDR, ctrl_val(1'b0, hv_ff), 1'b1, 1'b0};
                tmr_load  = 1'b1;
                tmr_cyc   = frps_pkg::CNT_W'(frps_pkg::NVH_CYC);
                nxt_state = S_WAIT_NVH;
            end
            S_WAIT_NVH:
                if (tmr_done)
                    nxt_state = S_CLR_HV;
            S_CLR_HV:
            begin
                nxt_bus   = '{frps_pkg::ARRAY_CONTROL_REG_ADDR, frps_pkg::CTRL_IDLE, 1'b1, 1'b0};
                nxt_hv    = 1'b0;
                tmr_load  = 1'b1;
                tmr_cyc   = frps_pkg::CNT_W'(frps_pkg::RCV_CYC);
                nxt_state = S_WAIT_RCV;
            end
            S_WAIT_RCV:
            begin
                if (tmr_done)
                begin
                    nxt_busy  = 1'b0;
                    nxt_done  = 1'b1;
                    nxt_state = S_IDLE;
                end
            end
        endcase

        // Halt mid-sequence suspends the device; unwind cleanly
        if (halt_ff && busy_ff && state_ff != S_CLR_PGM && state_ff != S_WAIT_NVH &&
            state_ff != S_CLR_HV && state_ff != S_WAIT_RCV)
        begin
            nxt_status = frps_pkg::FRPS_ERR_SUSPEND;
            nxt_req    = 1'b0;
            nxt_hv     = hv_ff;
            nxt_bus.wr = 1'b0;
            nxt_bus.rd = 1'b0;
            nxt_state  = S_CLR_PGM;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            state_ff  <= S_IDLE;
            bus_ff    <= '0;
            status_ff <= frps_pkg::FRPS_OK;
            row_ff    <= '0;
            idx_ff    <= '0;
            last_ff   <= '0;
            hv_ff     <= 1'b0;
            req_ff    <= 1'b0;
            busy_ff   <= 1'b0;
            done_ff   <= 1'b0;
        end
        else
        begin
            state_ff  <= nxt_state;
            bus_ff    <= nxt_bus;
            status_ff <= nxt_status;
            row_ff    <= nxt_row;
            idx_ff    <= nxt_idx;
            last_ff   <= nxt_last;
            hv_ff     <= nxt_hv;
            req_ff    <= nxt_req;
            busy_ff   <= nxt_busy;
            done_ff   <= nxt_done;
        end
    end
    assign o_bus      = bus_ff;
    assign o_status   = status_ff;
    assign o_data_req = req_ff;
    assign o_busy     = busy_ff;
    assign o_done     = done_ff;

endmodule

// >>> tb/frps_host_sva.sv
// Checker: order and timing of the host's device bus sequence
`timescale 1ns/1ps
module frps_host_sva
(
    // Clock and reset
    input wire logic                   i_core_clk,
    input wire logic                   i_rst,
    // User side
    input wire logic                   i_start,
    input wire frps_pkg::frps_cmd_t    i_cmd,
    input wire logic [7:0]             i_data,
    input wire logic                   o_data_req,
    input wire logic                   o_busy,
    input wire logic                   o_done,
    input wire frps_pkg::frps_status_t o_status,
    input wire logic                   i_halt_req,
    // Device bus
    input wire frps_pkg::frps_bus_t    o_bus,
    input wire logic [7:0]             i_bus_rdata
);
    // ****
    // Bus history
    // ****
    logic        hv_ff;
    logic        byte_ff;
    logic [15:0] row_ff;
    logic [15:0] gap_ff;
    logic        wr_c;
    logic        wr_a;
    assign wr_c = o_bus.wr && o_bus.addr == frps_pkg::ARRAY_CONTROL_REG_ADDR;
    assign wr_a = o_bus.wr && !wr_c;
    // Gap counts idle cycles since the last strobe, so spacing needs no deep $past
    always_ff @(posedge i_core_clk)
    begin
        gap_ff  <= (i_rst || o_bus.wr || o_bus.rd) ? 16'h0000 : gap_ff + 16'h0001;
        hv_ff   <= i_rst ? 1'b0 : (wr_c ? o_bus.wdata[3] : hv_ff);
        byte_ff <= i_rst ? 1'b0 : ((o_bus.wr || o_bus.rd) ? (wr_a && hv_ff) : byte_ff);
        row_ff  <= (wr_a && !hv_ff) ? o_bus.addr : row_ff;
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    sequence s_ctrl(v);
        wr_c && o_bus.wdata == v;
    endsequence
    sequence s_close;
        gap_ff >= frps_pkg::NVH_CYC - 1 ##[39:48] o_done;
    endsequence

    a_busy_on_start:
    assert property ($rose(o_busy) |-> $past(i_start) && !$past(o_busy))
        else $error("busy rose without start");
    a_ctrl_first:
    assert property ($rose(o_busy) |=> s_ctrl(8'h01))
        else $error("first write is not program select");
    a_bpr_after_pgm:
    assert property (s_ctrl(8'h01) |=> o_bus.rd
        && o_bus.addr == frps_pkg::BLOCK_PROTECT_REG_ADDR) else $error("no protect read");
    a_hv_needs_pgm:
    assert property (wr_c && o_bus.wdata[3] && !hv_ff
        |-> o_bus.wdata[1:0] == 2'b01 && gap_ff >= frps_pkg::NVS_CYC - 1)
        else $error("high voltage set out of sequence");
    a_byte_in_row:
    assert property (wr_a |-> o_bus.addr >= frps_pkg::ARRAY_LO_ADDR
        && o_bus.addr <= frps_pkg::ARRAY_HI_ADDR && (!hv_ff || o_bus.addr[15:6] == row_ff[15:6]))
        else $error("array write outside selected row");
    a_byte_spacing:
    assert property (o_bus.wr && hv_ff |-> gap_ff <= frps_pkg::PROG_CYC + 8
        && (!byte_ff || !wr_a || gap_ff >= frps_pkg::PROG_CYC - 1))
        else $error("byte spacing out of bounds");
    a_data_to_wr:
    assert property (o_data_req |-> ##2 wr_a && o_bus.wdata == $past(i_data))
        else $error("byte data not written");
    a_close_hold:
    assert property (wr_c && o_bus.wdata == 8'h00 && hv_ff |-> s_close)
        else $error("close down timing wrong");
    a_quiet_idle:
    assert property (o_bus.wr || o_bus.rd |-> o_busy)
        else $error("bus strobe while idle");
endmodule

bind frps_host frps_host_sva u_sva
(
    .i_core_clk (i_core_clk), .i_rst (i_rst), .i_start (i_start), .i_cmd (i_cmd),
    .i_data (i_data), .o_data_req (o_data_req), .o_busy (o_busy), .o_done (o_done),
    .o_status (o_status), .i_halt_req (i_halt_req), .o_bus (o_bus),
    .i_bus_rdata (i_bus_rdata)
);

// >>> tb/frps_dev_model.sv
// Device model: control, block protect and one row of array storage
`timescale 1ns/1ps
module frps_dev_model
#(
    parameter logic [7:0] BPR = 8'hff
)
(
    // Clock and reset
    input  wire logic                i_core_clk,
    input  wire logic                i_rst,
    // Host bus
    input  wire frps_pkg::frps_bus_t i_bus,
    // Answers and state
    output logic [7:0]               o_rdata,
    output logic [7:0]               o_err,
    output logic [7:0]               o_ctrl
);
    // ****
    // Array state
    // ****
    logic [7:0]  mem [64];
    logic        bpr_seen;
    logic        row_sel;
    logic [15:0] row;
    logic [15:0] a;
    logic [7:0]  d;
    logic        in_arr;
    logic        hv_ok;
    assign a      = i_bus.addr;
    assign d      = i_bus.wdata;
    assign in_arr = a >= frps_pkg::ARRAY_LO_ADDR && a <= frps_pkg::ARRAY_HI_ADDR;
    assign hv_ok  = d[0] && bpr_seen && row_sel && row < {1'b1, BPR, 7'h00};
    always_ff @(posedge i_core_clk)
    begin
        // Read data is held only one cycle; after that it wanders
        o_rdata <= ~o_rdata;
        if (i_rst)
        begin
            o_rdata  <= 8'h5a;
            o_err    <= 8'h00;
            o_ctrl   <= frps_pkg::CTRL_IDLE;
            bpr_seen <= 1'b0;
            row_sel  <= 1'b0;
        end
        else if (i_bus.rd && a == frps_pkg::BLOCK_PROTECT_REG_ADDR)
        begin
            o_rdata  <= BPR;
            bpr_seen <= o_ctrl[0];
        end
        else if (i_bus.wr && a == frps_pkg::ARRAY_CONTROL_REG_ADDR)
        begin
            if ((d[0] && d[1]) || (d[3] && !o_ctrl[3] && !hv_ok))
                o_err <= o_err + 8'h01;
            else
                o_ctrl <= d;
            if (d[0] && !o_ctrl[0])
            begin
                bpr_seen <= 1'b0;
                row_sel  <= 1'b0;
            end
        end
        else if (i_bus.wr && in_arr && o_ctrl[0] && !o_ctrl[3] && bpr_seen && !row_sel)
        begin
            row_sel <= 1'b1;
            row     <= a & frps_pkg::ROW_BASE_MASK;
        end
        else if (i_bus.wr && in_arr && o_ctrl[3] && (a & frps_pkg::ROW_BASE_MASK) == row)
            mem[a[5:0]] <= d;
        else if (i_bus.wr)
            o_err <= o_err + 8'h01;
    end
endmodule

// >>> tb/frps_host_tb.sv
// Testbench: programs rows through the host against the device model
`timescale 1ns/1ps
module frps_host_tb;
    // ****
    // Signals
    // ****
    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    logic                   start = 1'b0;
    logic                   halt = 1'b0;
    logic [7:0]             data = 8'h00;
    frps_pkg::frps_cmd_t    cmd = '0;
    logic                   req;
    logic                   busy;
    logic                   done;
    frps_pkg::frps_status_t st;
    frps_pkg::frps_bus_t    bus;
    logic [7:0]             rdata;
    logic [7:0]             err;
    logic [7:0]             ctrl;
    logic [7:0]             exp_mem [64];
    logic [31:0]            rnd = 32'h0e21f379;
    int                     k = 0;
    int                     cyc = 0;
    int                     n_mismatch = 0;
    int                     cmp_count = 0;

    frps_host DUT
    (
        .i_core_clk (clk), .i_rst (rst), .i_start (start), .i_cmd (cmd), .i_data (data),
        .o_data_req (req), .o_busy (busy), .o_done (done), .o_status (st),
        .i_halt_req (halt), .o_bus (bus), .i_bus_rdata (rdata)
    );
    frps_dev_model dev
    (
        .i_core_clk (clk), .i_rst (rst), .i_bus (bus), .o_rdata (rdata), .o_err (err),
        .o_ctrl (ctrl)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Halt wins over any address fault
    function automatic frps_pkg::frps_status_t exp_st(input logic [15:0] r, input int ht);
        logic [15:0] b;
        b = r & frps_pkg::ROW_BASE_MASK;
        if (ht > 0)
            return frps_pkg::FRPS_ERR_SUSPEND;
        if (b < frps_pkg::ARRAY_LO_ADDR || b > frps_pkg::ARRAY_HI_ADDR)
            return frps_pkg::FRPS_ERR_RANGE;
        return frps_pkg::FRPS_OK;
    endfunction

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic run(input logic [15:0] r, input logic [5:0] n, input int ht);
        int t;
        frps_pkg::frps_status_t es;
        es = exp_st(r, ht);
        repeat (3) @(negedge clk);
        cmd   = '{row_addr: r, count_m1: n};
        start = 1'b1;
        k     = 0;
        @(negedge clk);
        start = 1'b0;
        for (t = 1; done !== 1'b1; t++)
        begin
            halt = (ht > 0 && t >= ht);
            @(negedge clk);
        end
        halt = 1'b0;
        chk("status", 8'(es), 8'(st));
        chk("ctrl", 8'h00, ctrl);
        chk("err", 8'h00, err);
        chk("busy", 8'h00, {7'h00, busy});
        for (int i = 0; i <= n && es == frps_pkg::FRPS_OK; i++)
            chk("byte", exp_mem[i], dev.mem[i]);
    endtask

    initial
    begin
        forever #12.5 clk = ~clk;
    end

    // Ceiling sits about a sixth above the whole expected simulation, all runs together
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 100000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    always @(negedge clk)
    begin
        if (req === 1'b1)
        begin
            rnd = lfsr(rnd);
            data <= rnd[7:0];
            exp_mem[k] = rnd[7:0];
            k++;
        end
    end

    initial
    begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        chk("busy", 8'h00, {7'h00, busy});
        // Start while halted must be ignored
        halt = 1'b1;
        repeat (3) @(negedge clk);
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        @(negedge clk);
        chk("busy", 8'h00, {7'h00, busy});
        chk("ctrl", 8'h00, ctrl);
        halt = 1'b0;
        rnd = lfsr(rnd);
        run(16'h1000 | {2'b00, rnd[13:0]}, 6'h3f, 0);
        run(16'h0480, 6'h01, 0);
        run(16'h7fc0, 6'h00, 0);
        run(16'h0440, 6'h00, 0);
        run(16'h8000, 6'h00, 0);
        run(16'h2000, 6'h05, 300);
        run(16'h2040, 6'h05, 800);
        tally_and_finish();
    end
endmodule
